//--- core/ppp_port.sv
// Parallel port pin engine: standard printer and EPP cycles behind an APB slave.
// Assumes the peripheral pins arrive asynchronously and the bench resolves shared wires.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ppp_map.svh"

module ppp_port (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        ack_n_i,
	input  wire logic        busy_wait_i,
	input  wire logic        error_n_i,
	input  wire logic        no_media_i,
	input  wire logic        printer_online_i,
	input  wire logic [7:0]  port_data_bus_i,
	output logic      [7:0]  port_data_bus_o,
	output logic             port_data_bus_oe_o,
	output logic             data_strobe_n_o,
	output logic             data_strobe_oe_o,
	output logic             auto_line_feed_n_o,
	output logic             auto_line_feed_oe_o,
	output logic             select_printer_n_o,
	output logic             select_printer_oe_o,
	output logic             printer_init_n_o,
	output logic             printer_init_oe_o
);
	import ppp_pkg::*;

	localparam logic [8:0] SETUP_CYC  = 9'(`PPP_SETUP_CYC);
	localparam logic [8:0] STROBE_CYC = 9'(`PPP_STROBE_CYC);
	localparam logic [8:0] HOLD_CYC   = 9'(`PPP_HOLD_CYC);
	localparam logic [8:0] TMO_CYC    = 9'(`PPP_TMO_CYC);

	typedef struct packed {
		ppp_fsm_t    fsm;
		logic [8:0]  cnt;
		ppp_word_t   cur;
		logic        is_rd;
		logic [8:0]  ctrl;
		logic        ack_seen;
		logic        tmo;
		logic        rd_req;
		logic        rd_addr;
		logic        rd_valid;
		logic [7:0]  rd_data;
		ppp_pins_t   s1;
		ppp_pins_t   s2;
		ppp_pins_t   s3;
		ppp_pins_t   filt;
		logic [7:0]  p_data;
		logic        p_data_oe;
		logic        p_stb;
		logic        p_stb_oe;
		logic        p_feed;
		logic        p_feed_oe;
		logic        p_sel;
		logic        p_sel_oe;
		logic        p_init;
		logic        p_init_oe;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ppp_st_t;

	ppp_st_t   st;
	ppp_st_t   next_st;
	ppp_word_t fifo_out;
	logic      fifo_valid;
	logic      fifo_ready;
	logic      fifo_pop;
	logic      fifo_push;
	logic [4:0] fifo_cnt;
	ppp_pins_t pins_raw;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	assign pins_raw = {port_data_bus_i, printer_online_i, no_media_i, error_n_i,
		busy_wait_i, ack_n_i};

	// The pushed word is taken on the edge where the bus sees pready high.
	assign fifo_push = psel_i & penable_i & pwrite_i & st.pready & hit(paddr_i, `PPP_OFF_DATA);
	assign fifo_pop  = (st.fsm == PPP_IDLE) & fifo_valid;

	ppp_fifo #(
		.W(`PPP_FIFO_W),
		.D(`PPP_FIFO_D)
	) u_fifo (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_data_i   (pwdata_i[`PPP_FIFO_W-1:0]),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_ready),
		.out_data_o  (fifo_out),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.count_o     (fifo_cnt)
	);

	always_comb begin
		logic       wr_fx;
		logic       rd_fx;
		logic       ack_fall;
		logic       abort;
		logic       epp;
		logic       strobe;
		logic       wait_n;
		logic [7:0] din;
		wr_fx    = 1'b0;
		rd_fx    = 1'b0;
		ack_fall = 1'b0;
		abort    = 1'b0;
		epp      = 1'b0;
		strobe   = 1'b0;
		wait_n   = 1'b0;
		din      = 8'h00;
		next_st  = st;

		////////////////////////////////////////////////////////////////////
		// Pin synchronisers: a change is accepted once stages two and three agree.
		next_st.s1 = pins_raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 13; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.filt[i] = st.s3[i];
			end
		end
		ack_fall = st.filt[0] & ~next_st.filt[0];
		wait_n   = st.filt[1];
		din      = st.filt[12:5];

		////////////////////////////////////////////////////////////////////
		// APB slave: effects take place on the edge where pready is seen high.
		wr_fx = psel_i & penable_i & pwrite_i & st.pready;
		rd_fx = psel_i & penable_i & ~pwrite_i & st.pready;
		next_st.pready  = psel_i & penable_i & ~st.pready &
			~(pwrite_i & hit(paddr_i, `PPP_OFF_DATA) & ~fifo_ready);
		next_st.pslverr = 1'b0;
		next_st.prdata  = 32'h0000_0000;
		if (next_st.pready) begin
			next_st.pslverr = ~(hit(paddr_i, `PPP_OFF_CTRL) | hit(paddr_i, `PPP_OFF_DATA) |
				hit(paddr_i, `PPP_OFF_STATUS) | hit(paddr_i, `PPP_OFF_EPPRD));
			if (!pwrite_i) begin
				if (hit(paddr_i, `PPP_OFF_CTRL)) begin
					next_st.prdata = {23'h000000, st.ctrl};
				end else if (hit(paddr_i, `PPP_OFF_STATUS)) begin
					next_st.prdata = {17'h00000, fifo_cnt, ~fifo_ready, ~fifo_valid,
						(st.fsm != PPP_IDLE), ~st.filt[0], st.filt[4], st.filt[3],
						st.filt[2], st.filt[1], st.tmo, st.ack_seen};
				end else if (hit(paddr_i, `PPP_OFF_EPPRD)) begin
					next_st.prdata = {23'h000000, st.rd_valid, st.rd_data};
				end
			end
		end
		if (wr_fx && hit(paddr_i, `PPP_OFF_CTRL)) begin
			next_st.ctrl = pwdata_i[8:0];
			abort        = pwdata_i[`PPP_CTRL_ABORT];
		end
		if (wr_fx && hit(paddr_i, `PPP_OFF_EPPRD)) begin
			next_st.rd_req  = 1'b1;
			next_st.rd_addr = pwdata_i[`PPP_EPPRD_ADDR];
		end
		// Sticky flags: a new event in the clearing cycle wins.
		if (wr_fx && hit(paddr_i, `PPP_OFF_STATUS)) begin
			if (pwdata_i[`PPP_ST_ACK_SEEN]) begin
				next_st.ack_seen = 1'b0;
			end
			if (pwdata_i[`PPP_ST_TIMEOUT]) begin
				next_st.tmo = 1'b0;
			end
		end
		if (rd_fx && hit(paddr_i, `PPP_OFF_EPPRD)) begin
			next_st.rd_valid = 1'b0;
		end
		if (ack_fall) begin
			next_st.ack_seen = 1'b1;
		end

		////////////////////////////////////////////////////////////////////
		// Cycle engine.
		epp         = st.ctrl[`PPP_CTRL_MODE];
		next_st.cnt = st.cnt + 9'd1;
		unique case (st.fsm)
			PPP_IDLE: begin
				next_st.cnt = 9'd0;
				if (fifo_valid) begin
					next_st.cur   = fifo_out;
					next_st.is_rd = 1'b0;
					next_st.fsm   = epp ? PPP_EPP_SETUP : PPP_STD_SETUP;
				end else if (st.rd_req && epp) begin
					next_st.cur    = {st.rd_addr, 8'h00};
					next_st.is_rd  = 1'b1;
					next_st.rd_req = 1'b0;
					next_st.fsm    = PPP_EPP_SETUP;
				end
			end
			PPP_STD_SETUP: begin
				if (st.cnt == SETUP_CYC - 9'd1) begin
					next_st.cnt = 9'd0;
					next_st.fsm = PPP_STD_STROBE;
				end
			end
			PPP_STD_STROBE: begin
				if (st.cnt == STROBE_CYC - 9'd1) begin
					next_st.cnt = 9'd0;
					next_st.fsm = PPP_STD_HOLD;
				end
			end
			PPP_STD_HOLD: begin
				if (st.cnt == HOLD_CYC - 9'd1) begin
					next_st.cnt = 9'd0;
					next_st.fsm = PPP_STD_BUSY;
				end
			end
			PPP_STD_BUSY: begin
				if (!st.filt[1]) begin
					next_st.fsm = PPP_IDLE;
				end
			end
			PPP_EPP_SETUP: begin
				// A wait line still high from the last cycle would end this one at once.
				if (!wait_n) begin
					next_st.cnt = 9'd0;
					next_st.fsm = PPP_EPP_STROBE;
				end else if (st.cnt == TMO_CYC - 9'd1) begin
					next_st.tmo = 1'b1;
					next_st.fsm = PPP_IDLE;
				end
			end
			PPP_EPP_STROBE: begin
				if (wait_n && st.cnt != 9'd0) begin
					if (st.is_rd) begin
						next_st.rd_data  = din;
						next_st.rd_valid = 1'b1;
					end
					next_st.fsm = PPP_IDLE;
				end else if (st.cnt == TMO_CYC - 9'd1) begin
					next_st.tmo = 1'b1;
					next_st.fsm = PPP_IDLE;
				end
			end
		endcase
		if (abort) begin
			next_st.fsm = PPP_IDLE;
		end

		////////////////////////////////////////////////////////////////////
		// Pin drivers, registered from the next state so they leave flops directly.
		strobe               = (next_st.fsm == PPP_EPP_STROBE);
		next_st.p_data       = next_st.cur[7:0];
		next_st.p_init       = ~next_st.ctrl[`PPP_CTRL_INIT];
		next_st.p_init_oe    = ~next_st.ctrl[`PPP_CTRL_INIT_FLT];
		if (next_st.ctrl[`PPP_CTRL_MODE]) begin
			// Strobe, feed and select take their EPP roles and are always driven.
			next_st.p_stb     = ~((next_st.fsm == PPP_EPP_SETUP | strobe) & ~next_st.is_rd);
			next_st.p_feed    = ~(strobe & ~next_st.cur[8]);
			next_st.p_sel     = ~(strobe & next_st.cur[8]);
			next_st.p_stb_oe  = 1'b1;
			next_st.p_feed_oe = 1'b1;
			next_st.p_sel_oe  = 1'b1;
			next_st.p_data_oe = ~(next_st.fsm != PPP_IDLE & next_st.is_rd) &
				~next_st.ctrl[`PPP_CTRL_DIR];
		end else begin
			next_st.p_stb     = ~(next_st.fsm == PPP_STD_STROBE);
			next_st.p_stb_oe  = next_st.ctrl[`PPP_CTRL_STB_EN];
			next_st.p_feed    = ~next_st.ctrl[`PPP_CTRL_FEED];
			next_st.p_feed_oe = next_st.ctrl[`PPP_CTRL_FEED_EN];
			next_st.p_sel     = ~next_st.ctrl[`PPP_CTRL_SEL];
			next_st.p_sel_oe  = next_st.ctrl[`PPP_CTRL_SEL_EN];
			next_st.p_data_oe = ~next_st.ctrl[`PPP_CTRL_DIR];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st           <= '0;
			st.fsm       <= PPP_IDLE;
			st.ctrl      <= `PPP_CTRL_RESET;
			st.s1        <= 13'h1fff;
			st.s2        <= 13'h1fff;
			st.s3        <= 13'h1fff;
			st.filt      <= 13'h1fff;
			st.p_data_oe <= 1'b1;
			st.p_stb     <= 1'b1;
			st.p_stb_oe  <= 1'b1;
			st.p_feed    <= 1'b1;
			st.p_feed_oe <= 1'b1;
			st.p_sel     <= 1'b1;
			st.p_sel_oe  <= 1'b1;
			st.p_init    <= 1'b1;
			st.p_init_oe <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o            = st.prdata;
	assign pready_o            = st.pready;
	assign pslverr_o           = st.pslverr;
	assign port_data_bus_o     = st.p_data;
	assign port_data_bus_oe_o  = st.p_data_oe;
	assign data_strobe_n_o     = st.p_stb;
	assign data_strobe_oe_o    = st.p_stb_oe;
	assign auto_line_feed_n_o  = st.p_feed;
	assign auto_line_feed_oe_o = st.p_feed_oe;
	assign select_printer_n_o  = st.p_sel;
	assign select_printer_oe_o = st.p_sel_oe;
	assign printer_init_n_o    = st.p_init;
	assign printer_init_oe_o   = st.p_init_oe;

endmodule

`default_nettype wire

//--- core/ppp_map.svh
// Register offsets, field positions, reset values and timing counts of the port.
// Assumes a 25 MHz core clock and a 32-bit APB register bus.
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH

`define PPP_CLK_MHZ        25
`define PPP_OFF_CTRL       12'h000
`define PPP_OFF_DATA       12'h004
`define PPP_OFF_STATUS     12'h008
`define PPP_OFF_EPPRD      12'h00c

`define PPP_CTRL_MODE      0
`define PPP_CTRL_DIR       1
`define PPP_CTRL_STB_EN    2
`define PPP_CTRL_FEED_EN   3
`define PPP_CTRL_INIT_FLT  4
`define PPP_CTRL_SEL_EN    5
`define PPP_CTRL_SEL       6
`define PPP_CTRL_FEED      7
`define PPP_CTRL_INIT      8
`define PPP_CTRL_ABORT     9
`define PPP_CTRL_RESET     9'h02c

`define PPP_ST_ACK_SEEN    0
`define PPP_ST_TIMEOUT     1
`define PPP_EPPRD_ADDR     8
`define PPP_EPPRD_VALID    8

`define PPP_SETUP_NS       1000
`define PPP_STROBE_NS      1000
`define PPP_HOLD_NS        1000
`define PPP_TMO_NS         10000
`define PPP_SETUP_CYC      ((`PPP_SETUP_NS * `PPP_CLK_MHZ + 999) / 1000)
`define PPP_STROBE_CYC     ((`PPP_STROBE_NS * `PPP_CLK_MHZ + 999) / 1000)
`define PPP_HOLD_CYC       ((`PPP_HOLD_NS * `PPP_CLK_MHZ + 999) / 1000)
`define PPP_TMO_CYC        ((`PPP_TMO_NS * `PPP_CLK_MHZ) / 1000)

`define PPP_FIFO_W         9
`define PPP_FIFO_D         16

`endif

//--- core/ppp_pkg.sv
// Types shared by the parallel port logic.
// Assumes ppp_map.svh is reachable on the include path.
`include "ppp_map.svh"

package ppp_pkg;

	typedef enum logic [2:0] {
		PPP_IDLE,
		PPP_STD_SETUP,
		PPP_STD_STROBE,
		PPP_STD_HOLD,
		PPP_STD_BUSY,
		PPP_EPP_SETUP,
		PPP_EPP_STROBE
	} ppp_fsm_t;

	typedef logic [`PPP_FIFO_W-1:0] ppp_word_t;
	typedef logic [12:0]            ppp_pins_t;

endpackage

//--- core/ppp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module ppp_fifo #(
	parameter int W = 9,
	parameter int D = 16,
	parameter int A = $clog2(D)
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [A:0]        count_o
);

	typedef struct packed {
		logic [A-1:0] wr;
		logic [A-1:0] rd;
		logic [A:0]   cnt;
	} ppp_fifo_st_t;

	ppp_fifo_st_t st;
	ppp_fifo_st_t next_st;
	logic [W-1:0] mem [D];
	logic         push;
	logic         pop;

	assign in_ready_o  = (st.cnt != D[A:0]);
	assign out_valid_o = (st.cnt != '0);
	assign out_data_o  = mem[st.rd];
	assign count_o     = st.cnt;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr = (st.wr == A'(D - 1)) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == A'(D - 1)) ? '0 : st.rd + 1'b1;
		end
		next_st.cnt = st.cnt + {{A{1'b0}}, push} - {{A{1'b0}}, pop};
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Storage has no reset; only the pointers and the count define what is valid.
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[st.wr] <= in_data_i;
		end
	end

endmodule

`default_nettype wire

//--- testbench/ppp_port_asserts.sv
// Concurrent checks on the pins and the bus of the parallel port.
// Assumes it is bound to ppp_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ppp_port_asserts (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic [7:0]  port_data_bus_o,
	input wire logic        port_data_bus_oe_o,
	input wire logic        data_strobe_n_o,
	input wire logic        data_strobe_oe_o,
	input wire logic        auto_line_feed_n_o,
	input wire logic        auto_line_feed_oe_o,
	input wire logic        select_printer_n_o,
	input wire logic        select_printer_oe_o,
	input wire logic        printer_init_n_o,
	input wire logic        printer_init_oe_o
);
	logic [9:0] ctl;
	logic       wr;
	logic       ep;
	assign wr = psel_i & penable_i & pready_o & pwrite_i & (paddr_i == 12'h000);
	assign ep = ctl[0];

	// Shadow of the control word, so that the checks know the mode.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			ctl <= 10'h02c;
		else if (wr)
			ctl <= pwdata_i[9:0];
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	chk_strobe_float: assert property (
		wr |-> ##2 data_strobe_oe_o == (ctl[0] | ctl[2]) && select_printer_oe_o == (ctl[0] | ctl[5]))
		else $error("strobe or select drive wrong");
	chk_feed_pin: assert property (
		wr |-> ##2 auto_line_feed_oe_o == (ctl[0] | ctl[3]) && (ctl[0] || auto_line_feed_n_o == !ctl[7]))
		else $error("feed pin wrong");
	chk_init_pin: assert property (
		wr |-> ##2 printer_init_oe_o == !ctl[4] && printer_init_n_o == !ctl[8])
		else $error("init pin wrong");
	chk_select_level: assert property (
		wr && !pwdata_i[0] |-> ##2 select_printer_n_o == !ctl[6])
		else $error("select level wrong");
	chk_std_strobe: assert property (
		!ep && $fell(data_strobe_n_o) |->
		(port_data_bus_oe_o && !data_strobe_n_o && $stable(port_data_bus_o)) [*8])
		else $error("strobe without steady data");
	chk_epp_abort: assert property (
		wr && pwdata_i[9] && pwdata_i[0] |->
		##[1:2] data_strobe_n_o && auto_line_feed_n_o && select_printer_n_o)
		else $error("abort left a strobe low");
	chk_epp_lead: assert property (
		ep && ($fell(auto_line_feed_n_o) || $fell(select_printer_n_o)) |->
		data_strobe_n_o == !port_data_bus_oe_o)
		else $error("write strobe out of step");
	chk_epp_bounded: assert property (
		ep && ($fell(auto_line_feed_n_o) || $fell(select_printer_n_o)) |->
		##[1:300] auto_line_feed_n_o && select_printer_n_o)
		else $error("cycle strobe stuck low");
	chk_reset_pins: assert property (
		$rose(nrst_i) |-> port_data_bus_oe_o && port_data_bus_o == 8'h00 && data_strobe_n_o
		&& auto_line_feed_n_o && select_printer_n_o && printer_init_n_o)
		else $error("pins wrong after reset");
endmodule

bind ppp_port ppp_port_asserts chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pready_o(pready_o), .port_data_bus_o(port_data_bus_o),
	.port_data_bus_oe_o(port_data_bus_oe_o), .data_strobe_n_o(data_strobe_n_o),
	.data_strobe_oe_o(data_strobe_oe_o), .auto_line_feed_n_o(auto_line_feed_n_o),
	.auto_line_feed_oe_o(auto_line_feed_oe_o), .select_printer_n_o(select_printer_n_o),
	.select_printer_oe_o(select_printer_oe_o), .printer_init_n_o(printer_init_n_o),
	.printer_init_oe_o(printer_init_oe_o));

`default_nettype wire

//--- testbench/ppp_printer_model.sv
// Behavioural printer and EPP peripheral on the far side of the port pins.
// Assumes the bench resolves the pull-ups and the shared data lines.
`timescale 1ns/1ps
`default_nettype none

module ppp_printer_model #(
	parameter int BUSY_CYC = 30
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       epp_i,
	input  wire logic [7:0] stall_i,
	input  wire logic [7:0] bus_i,
	input  wire logic       wr_n_i,
	input  wire logic       dat_n_i,
	input  wire logic       adr_n_i,
	output logic            ack_n_o,
	output logic            busy_wait_o,
	output logic      [7:0] data_o,
	output logic      [7:0] got_o,
	output logic      [7:0] cnt_o,
	output logic            adr_o
);
	logic       pw;
	logic       pc;
	logic [7:0] t;
	logic       cyc;
	assign cyc = !dat_n_i || !adr_n_i;

	// A stall of 8'hff never answers, so the port must time out or abort.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{ack_n_o, busy_wait_o, data_o, got_o, cnt_o, adr_o, pw, pc, t} <=
				{2'b10, 24'h0, 1'b0, 2'b10, 8'h00};
		end else begin
			pw <= wr_n_i;
			pc <= cyc;
			t <= (t != 8'h00) ? t - 8'h01 : t;
			if (!epp_i && pw && !wr_n_i) begin
				got_o <= bus_i;
				cnt_o <= cnt_o + 8'h01;
				busy_wait_o <= 1'b1;
				t <= 8'(BUSY_CYC);
			end
			if (!epp_i && busy_wait_o && t == 8'h04)
				ack_n_o <= 1'b0;
			if (!epp_i && busy_wait_o && t == 8'h01) begin
				ack_n_o <= 1'b1;
				busy_wait_o <= 1'b0;
			end
			if (epp_i && cyc && !pc) begin
				t <= stall_i;
				adr_o <= !adr_n_i;
				if (!wr_n_i) begin
					got_o <= bus_i;
					cnt_o <= cnt_o + 8'h01;
				end else
					data_o <= 8'h5a;
			end
			if (epp_i && cyc && pc && t == 8'h00 && stall_i != 8'hff)
				busy_wait_o <= 1'b1;
			if (epp_i && !cyc && pc) begin
				busy_wait_o <= 1'b0;
				t <= 8'h05;
			end
			if (epp_i && !cyc && !pc && t == 8'h01)
				data_o <= ~data_o;
		end
	end
endmodule

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the parallel port pin engine.
// Assumes the design, the checker and the peripheral model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk, nrst, psel, pen, pwr, perr, prdy, rer;
	logic [11:0] padr;
	logic [31:0] pwd, prd, rd;
	logic        ackn, bsy, errn, nomed, onl, boe, epp, adr;
	logic        ston, stoe, fdn, fdoe, sln, sloe, inn, inoe, stw, fdw, slw;
	logic [7:0]  bin, bout, mdat, stall, got, cnt;
	int          fails = 0;
	int          checked = 0;

	// External pull-ups hold floated strobes high.
	assign stw = stoe ? ston : 1'b1;
	assign fdw = fdoe ? fdn : 1'b1;
	assign slw = sloe ? sln : 1'b1;
	assign bin = boe ? bout : mdat;

	ppp_port dut_u (
		.clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.ack_n_i(ackn), .busy_wait_i(bsy), .error_n_i(errn), .no_media_i(nomed),
		.printer_online_i(onl), .port_data_bus_i(bin), .port_data_bus_o(bout),
		.port_data_bus_oe_o(boe), .data_strobe_n_o(ston), .data_strobe_oe_o(stoe),
		.auto_line_feed_n_o(fdn), .auto_line_feed_oe_o(fdoe), .select_printer_n_o(sln),
		.select_printer_oe_o(sloe), .printer_init_n_o(inn), .printer_init_oe_o(inoe));
	ppp_printer_model pm_u (
		.clk_i(clk), .nrst_i(nrst), .epp_i(epp), .stall_i(stall), .bus_i(bin),
		.wr_n_i(stw), .dat_n_i(fdw), .adr_n_i(slw), .ack_n_o(ackn), .busy_wait_o(bsy),
		.data_o(mdat), .got_o(got), .cnt_o(cnt), .adr_o(adr));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rd = prd;
		rer = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((rd & m) !== v && n < 1000);
		chk("poll", rd & m, v);
	endtask

	task automatic t_reset();
		chk("reset pins", {boe, bout, ston, fdn, sln, inn, stoe, fdoe, sloe, inoe}, 17'h100ff);
		apb(1'b1, 12'h010, 32'h0);
		chk("unmapped error", rer, 1'b1);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl reset", rd, 32'h02c);
	endtask

	task automatic t_ctrl();
		logic [9:0] v [4] = '{10'h000, 10'h010, 10'h06c, 10'h1ae};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, {22'h0, v[i]});
			repeat (3) @(posedge clk);
			chk("ctrl pins", {stoe, fdoe, sloe, inoe, sln, fdn, inn, boe}, {v[i][2], v[i][3],
				v[i][5], !v[i][4], !v[i][6], !v[i][7], !v[i][8], !v[i][1]});
		end
	endtask

	task automatic t_std();
		apb(1'b1, 12'h000, 32'h02c);
		for (int i = 0; i < 18; i++)
			apb(1'b1, 12'h004, 32'h40 + i);
		apb(1'b0, 12'h008, 32'h0);
		chk("fifo full", rd[14:8], {5'd16, 2'b10});
		poll(12'h008, 32'h180, 32'h100);
		chk("last byte", {cnt, got}, 16'h1251);
		apb(1'b0, 12'h008, 32'h0);
		chk("ack seen", rd[0], 1'b1);
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk("ack cleared", rd[0], 1'b0);
	endtask

	task automatic t_status();
		logic [2:0] p;
		for (int i = 0; i < 2; i++) begin
			p = i ? 3'b101 : 3'b010;
			{onl, nomed, errn} <= p;
			repeat (6) @(posedge clk);
			apb(1'b0, 12'h008, 32'h0);
			chk("pin status", rd[6:2], {1'b0, p, 1'b0});
		end
	endtask

	task automatic t_epp();
		epp <= 1'b1;
		apb(1'b1, 12'h000, 32'h02d);
		repeat (3) @(posedge clk);
		chk("epp drive", {stoe, fdoe, sloe, inoe, ston, fdn, sln}, 7'h7f);
		for (int i = 0; i < 2; i++) begin
			stall <= i ? 8'd40 : 8'd2;
			apb(1'b1, 12'h004, i ? 32'h0aa : 32'h155);
			poll(12'h008, 32'h180, 32'h100);
			chk("epp byte", {adr, got}, i ? 9'h0aa : 9'h155);
		end
		stall <= 8'd3;
		apb(1'b1, 12'h004, 32'h011);
		apb(1'b1, 12'h004, 32'h022);
		poll(12'h008, 32'h180, 32'h100);
		chk("epp pair", {cnt, got}, 16'h1622);
		apb(1'b1, 12'h00c, 32'h0);
		poll(12'h00c, 32'h100, 32'h100);
		chk("epp read", rd[8:0], 9'h15a);
		apb(1'b0, 12'h00c, 32'h0);
		chk("read clears", rd[8:0], 9'h05a);
	endtask

	task automatic t_abort();
		stall <= 8'hff;
		apb(1'b1, 12'h004, 32'h033);
		repeat (20) @(posedge clk);
		chk("stretched", fdn, 1'b0);
		apb(1'b1, 12'h000, 32'h22d);
		repeat (2) @(posedge clk);
		chk("aborted", {ston, fdn, sln}, 3'b111);
		apb(1'b1, 12'h004, 32'h034);
		poll(12'h008, 32'h002, 32'h002);
		apb(1'b1, 12'h008, 32'h002);
		apb(1'b0, 12'h008, 32'h0);
		chk("timeout cleared", rd[1], 1'b0);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		print_verdict();
	end

	initial begin
		{nrst, psel, pen, pwr} = 4'h0;
		padr = 12'h000;
		pwd = 32'h0;
		{errn, nomed, onl, epp} = 4'b1010;
		stall = 8'h00;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_ctrl();
		t_std();
		t_status();
		t_epp();
		t_abort();
		print_verdict();
	end
endmodule

`default_nettype wire
